// *** verilog/bcoe_core.v ***
/*
  Execute stage for a subset of the 8-bit core instruction set: OR with
  file, file increment, file move, accumulator store, literal load,
  unconditional jump and idle. Holds the file memory, accumulator, zero
  flag, program counter and program counter high latch.
  Assumes one program word is presented per clock, one clock being one
  instruction cycle, and that words outside the subset are handled
  elsewhere (here they advance the counter and raise foreign_q).
*/
`timescale 1ns/100ps
`include "bcoe_map.vh"

// Behaviour
// RQ1 - OR accumulator with file, destination bit
// RQ2 - Increment file into chosen destination, zero flag
// RQ3 - Jump loads 11-bit operand into counter
// RQ4 - Jump upper counter bits from latch 4:3
// RQ5 - Jump takes two cycles, flush cycle
// RQ6 - Move file to accumulator or itself
// RQ7 - Move updates zero flag, one cycle
// RQ8 - Store accumulator to file, flags kept
// RQ9 - Literal into accumulator, flags kept, one cycle
// RQ10 - Idle only advances the counter
module bcoe_core (
  sys_clk,
  rst_n,
  instr_word,
  instr_valid,
  obs_addr,
  pc_q,
  acc_q,
  zero_q,
  flush_q,
  retire_q,
  foreign_q,
  obs_data_q
);

  input  wire                   sys_clk;
  input  wire                   rst_n;
  input  wire [`BCOE_IW_W-1:0]  instr_word;
  input  wire                   instr_valid;
  input  wire [`BCOE_FA_W-1:0]  obs_addr;
  output reg  [`BCOE_PC_W-1:0]  pc_q;
  output reg  [7:0]             acc_q;
  output reg                    zero_q;
  output reg                    flush_q;
  output reg                    retire_q;
  output reg                    foreign_q;
  output reg  [7:0]             obs_data_q;

  reg  [7:0]             file_mem [0:`BCOE_DEPTH-1];
  reg  [7:0]             pch_q;

  wire [`BCOE_FA_W-1:0]  faddr;
  wire                   dest_f;
  wire                   take;
  wire                   is_or;
  wire                   is_inc;
  wire                   is_move;
  wire                   is_store;
  wire                   is_lit;
  wire                   is_jmp;
  wire                   is_idle;
  wire                   is_byte;
  wire [7:0]             fval;
  wire [7:0]             alu_res;
  wire                   alu_zero;
  reg  [1:0]             alu_sel;

  // Next values of the state registers
  reg  [`BCOE_PC_W-1:0]  pc_d;
  reg  [7:0]             acc_d;
  reg                    zero_d;
  reg  [7:0]             pch_d;
  reg                    file_we;
  reg  [7:0]             file_wdata;
  wire                   known;
  wire                   hit_pch;
  wire [7:0]             obs_data_d;

  assign faddr    = instr_word[`BCOE_FA_W-1:0];
  assign dest_f   = instr_word[`BCOE_DEST_BIT];
  // A word arriving in the flush cycle after a jump is discarded
  assign take     = instr_valid & ~flush_q; // RQ5
  assign is_or    = (instr_word & `BCOE_MASK_BYTE) == `BCOE_OP_OR_F;
  assign is_inc   = (instr_word & `BCOE_MASK_BYTE) == `BCOE_OP_INC_F;
  assign is_move  = (instr_word & `BCOE_MASK_BYTE) == `BCOE_OP_MOVE_F;
  assign is_store = (instr_word & `BCOE_MASK_STORE) == `BCOE_OP_STORE;
  assign is_lit   = (instr_word & `BCOE_MASK_LIT) == `BCOE_OP_LOAD_LIT;
  assign is_jmp   = (instr_word & `BCOE_MASK_JMP) == `BCOE_OP_JMP;
  assign is_idle  = (instr_word & `BCOE_MASK_IDLE) == `BCOE_OP_IDLE;
  assign is_byte  = is_or | is_inc | is_move;
  assign known    = is_byte | is_store | is_lit | is_jmp | is_idle;
  assign hit_pch  = (faddr == `BCOE_PCH_ADDR);

  // The latch lives outside the array so it has a reset value
  assign fval = (faddr == `BCOE_PCH_ADDR) ? pch_q : file_mem[faddr];

  // Observe port sees the latch at its file address as well
  assign obs_data_d = (obs_addr == `BCOE_PCH_ADDR) ? pch_q : file_mem[obs_addr];

  always @* begin
    if (is_or) begin
      alu_sel = `BCOE_ALU_OR;
    end else if (is_inc) begin
      alu_sel = `BCOE_ALU_INC;
    end else if (is_move) begin
      alu_sel = `BCOE_ALU_PASS_F;
    end else begin
      alu_sel = `BCOE_ALU_PASS_K;
    end
  end

  bcoe_alu u_alu (
    .sel     (alu_sel),
    .acc     (acc_q),
    .fval    (fval),
    .lit     (instr_word[7:0]),
    .result  (alu_res),
    .is_zero (alu_zero)
  );

  // Write port of the file array; the latch address never lands here
  always @* begin
    file_we    = 1'b0;
    file_wdata = acc_q;
    if (take && !hit_pch) begin
      if (is_byte && dest_f) begin
        file_we    = 1'b1;
        file_wdata = alu_res; // RQ1 RQ2 RQ6
      end else if (is_store) begin
        file_we    = 1'b1;
        file_wdata = acc_q; // RQ8
      end
    end
  end

  // File array has no reset; contents are undefined until written
  always @(posedge sys_clk) begin
    if (file_we) begin
      file_mem[faddr] <= file_wdata;
    end
  end

  // Program counter: jump target or the next word
  always @* begin
    pc_d = pc_q;
    if (take) begin
      if (is_jmp) begin
        pc_d = {pch_q[`BCOE_PCH_HI:`BCOE_PCH_LO], // RQ4
                instr_word[`BCOE_JMP_K_W-1:0]}; // RQ3
      end else begin
        pc_d = pc_q + 13'h0001; // RQ10
      end
    end
  end

  // Accumulator: byte result with destination bit clear, or a literal
  always @* begin
    acc_d = acc_q;
    if (take) begin
      if (is_byte && !dest_f) begin
        acc_d = alu_res; // RQ1 RQ2 RQ6
      end else if (is_lit) begin
        acc_d = instr_word[7:0]; // RQ9
      end
    end
  end

  // Zero flag: only byte operations touch it; store and literal keep it
  always @* begin
    zero_d = zero_q;
    if (take && is_byte) begin
      zero_d = alu_zero; // RQ1 RQ2 RQ7
    end
  end

  // High latch: written at its file address by byte results or a store
  always @* begin
    pch_d = pch_q;
    if (take && hit_pch) begin
      if (is_byte && dest_f) begin
        pch_d = alu_res;
      end else if (is_store) begin
        pch_d = acc_q; // RQ8
      end
    end
  end

  // Architectural state
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_q   <= `BCOE_RST_PC;
      acc_q  <= `BCOE_RST_ACC;
      zero_q <= 1'b0;
      pch_q  <= `BCOE_RST_PCH;
    end else begin
      pc_q   <= pc_d;
      acc_q  <= acc_d;
      zero_q <= zero_d;
      pch_q  <= pch_d;
    end
  end

  // One-cycle status pulses and the observe port
  // The flush pulse blocks the word behind a jump, as the fetch path refills
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flush_q    <= 1'b0;
      retire_q   <= 1'b0;
      foreign_q  <= 1'b0;
      obs_data_q <= 8'h00;
    end else begin
      flush_q    <= take & is_jmp; // RQ5
      retire_q   <= take;
      foreign_q  <= take & ~known;
      obs_data_q <= obs_data_d;
    end
  end

endmodule // bcoe_core

// *** verilog/bcoe_map.vh ***
/*
  Constants for the byte operation execute core: opcode patterns, field
  positions, reset values and the fixed file location of the high latch.
  Assumes the 14-bit program word format of the surrounding core.
*/
`ifndef BCOE_MAP_VH
`define BCOE_MAP_VH

`define BCOE_IW_W          14
`define BCOE_PC_W          13
`define BCOE_FA_W          7
`define BCOE_DEPTH         128
`define BCOE_DEST_BIT      7
`define BCOE_JMP_K_W       11
`define BCOE_PCH_LO        3
`define BCOE_PCH_HI        4

// Opcode patterns, compared under the masks below
`define BCOE_MASK_BYTE     14'h3F00
`define BCOE_OP_OR_F       14'h0400
`define BCOE_OP_INC_F      14'h0A00
`define BCOE_OP_MOVE_F     14'h0800
`define BCOE_MASK_STORE    14'h3F80
`define BCOE_OP_STORE      14'h0080
`define BCOE_MASK_LIT      14'h3C00
`define BCOE_OP_LOAD_LIT   14'h3000
`define BCOE_MASK_JMP      14'h3800
`define BCOE_OP_JMP        14'h2800
`define BCOE_MASK_IDLE     14'h3F9F
`define BCOE_OP_IDLE       14'h0000

// ALU selects
`define BCOE_ALU_OR        2'h0
`define BCOE_ALU_INC       2'h1
`define BCOE_ALU_PASS_F    2'h2
`define BCOE_ALU_PASS_K    2'h3

// File address of the program counter high latch
`define BCOE_PCH_ADDR      7'h0A

`define BCOE_RST_PC        13'h0000
`define BCOE_RST_ACC       8'h00
`define BCOE_RST_PCH       8'h00

`endif

// *** verilog/bcoe_alu.v ***
/*
  Combinational result unit: OR, increment and pass-through of file or
  literal operands, with a zero indication of the result.
  Assumes operands are stable for the whole instruction cycle.
*/
`timescale 1ns/100ps
`include "bcoe_map.vh"

module bcoe_alu (
  input  wire [1:0] sel,
  input  wire [7:0] acc,
  input  wire [7:0] fval,
  input  wire [7:0] lit,
  output reg  [7:0] result,
  output wire       is_zero
);

  always @* begin
    case (sel)
      `BCOE_ALU_OR:     result = acc | fval; // RQ1
      `BCOE_ALU_INC:    result = fval + 8'h01; // RQ2
      `BCOE_ALU_PASS_F: result = fval; // RQ6
      default:          result = lit; // RQ9
    endcase
  end

  assign is_zero = (result == 8'h00);

endmodule // bcoe_alu

// *** bench/bcoe_asserts.sv ***
/* Port checks for bcoe_core.
   Assumes one clock, bound by name to every bcoe_core. */
`timescale 1ns/100ps
`include "bcoe_map.vh"
module bcoe_asserts (
  input wire        sys_clk,
  input wire        rst_n,
  input wire [13:0] instr_word,
  input wire        instr_valid,
  input wire [12:0] pc_q,
  input wire [7:0]  acc_q,
  input wire        zero_q,
  input wire        flush_q,
  input wire        retire_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire [13:0] w = instr_word;
  wire tk = instr_valid & ~flush_q;
  wire jp = tk && (w & `BCOE_MASK_JMP) == `BCOE_OP_JMP;
  wire lt = tk && (w & `BCOE_MASK_LIT) == `BCOE_OP_LOAD_LIT;
  wire st = tk && (w & `BCOE_MASK_STORE) == `BCOE_OP_STORE;
  wire id = tk && (w & `BCOE_MASK_IDLE) == `BCOE_OP_IDLE;
  wire orr = tk && !w[7] && (w & `BCOE_MASK_BYTE) == `BCOE_OP_OR_F;
  wire inc = tk && !w[7] && (w & `BCOE_MASK_BYTE) == `BCOE_OP_INC_F;
  wire mv = tk && !w[7] && (w & `BCOE_MASK_BYTE) == `BCOE_OP_MOVE_F;
  a_jump_low: assert property (jp |=> pc_q[10:0] == $past(w[10:0]))
    else $error("jump low bits wrong");
  a_jump_flush: assert property (jp |=> flush_q && retire_q ##1 !flush_q)
    else $error("jump flush wrong");
  a_flush_hold: assert property (flush_q |=> $stable(acc_q) && $stable(pc_q))
    else $error("flushed word ran");
  a_lit_load: assert property (lt |=> acc_q == $past(w[7:0]) && $stable(zero_q))
    else $error("literal load wrong");
  a_store_keep: assert property (st |=> $stable(acc_q) && $stable(zero_q))
    else $error("store changed acc or flag");
  a_idle_pc: assert property (id |=> pc_q == $past(pc_q) + 13'h0001 && $stable(acc_q))
    else $error("idle wrong");
  a_or_acc: assert property (orr |=> (acc_q | $past(acc_q)) == acc_q && zero_q == !acc_q)
    else $error("or result wrong");
  a_inc_zero: assert property (inc |=> zero_q == (acc_q == 8'h00))
    else $error("increment flag wrong");
  a_move_zero: assert property (mv |=> zero_q == (acc_q == 8'h00))
    else $error("move flag wrong");
  c_jump: cover property (jp ##1 instr_valid);
  c_or: cover property (orr ##1 zero_q);
  c_inc: cover property (inc ##1 zero_q);
endmodule // bcoe_asserts
bind bcoe_core bcoe_asserts chk_u (.*);

// *** bench/test_byte_op_execute_subset.sv ***
/* Directed bench for bcoe_core.
   Assumes the core and its checker are compiled first. */
`timescale 1ns/100ps
module test_byte_op_execute_subset;
  reg         sys_clk = 0;
  reg         rst_n = 0;
  reg  [13:0] instr_word = 0;
  reg         instr_valid = 0;
  reg  [6:0]  obs_addr = 0;
  reg  [12:0] ep = 0;
  wire [12:0] pc_q;
  wire [7:0]  acc_q, obs_data_q;
  wire        zero_q, flush_q, retire_q, foreign_q;
  int         fail_count = 0, n_checks = 0;
  always #50 sys_clk = ~sys_clk;
  bcoe_core dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .instr_word(instr_word),
    .instr_valid(instr_valid), .obs_addr(obs_addr), .pc_q(pc_q), .acc_q(acc_q),
    .zero_q(zero_q), .flush_q(flush_q), .retire_q(retire_q), .foreign_q(foreign_q),
    .obs_data_q(obs_data_q));
  task c(input string s, input [12:0] e, input [12:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  task ex(input [13:0] v);
    @(posedge sys_clk);
    instr_word <= v;
    instr_valid <= 1'b1;
    ep = ep + 13'h0001;
  endtask
  // Lowers valid on the edge that takes the last word, then looks
  task sv;
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    #1;
  endtask
  task rd(input [6:0] a, input [7:0] e);
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    obs_addr <= a;
    @(posedge sys_clk);
    #1;
    c("file", {5'h00, e}, {5'h00, obs_data_q});
  endtask
  task t_lit_store;
    ex(14'h3000);
    sv;
    c("zero", 13'h0000, {12'h000, zero_q});
    ex(14'h305A);
    ex(14'h00A0);
    sv;
    c("acc", 13'h005A, {5'h00, acc_q});
    c("pc", ep, pc_q);
    rd(7'h20, 8'h5A);
    $display("lit store done");
  endtask
  task t_or;
    ex(14'h300F);
    ex(14'h04A0);
    rd(7'h20, 8'h5F);
    ex(14'h3000);
    ex(14'h00A1);
    ex(14'h0421);
    sv;
    c("zero", 13'h0001, {12'h000, zero_q});
    $display("or done");
  endtask
  task t_inc_move;
    ex(14'h30FF);
    ex(14'h00A2);
    ex(14'h0AA2);
    rd(7'h22, 8'h00);
    c("zero", 13'h0001, {12'h000, zero_q});
    ex(14'h0A22);
    ex(14'h08A2);
    sv;
    c("acc", 13'h0001, {5'h00, acc_q});
    c("zero", 13'h0001, {12'h000, zero_q});
    ex(14'h0820);
    ex(14'h0060);
    sv;
    c("acc", 13'h005F, {5'h00, acc_q});
    c("pc", ep, pc_q);
    c("foreign", 13'h0000, {12'h000, foreign_q});
    $display("inc move idle done");
  endtask
  task t_jump;
    ex(14'h3018);
    ex(14'h008A);
    ex(14'h2D55);
    ex(14'h3077);
    #1;
    c("flush", 13'h0001, {12'h000, flush_q});
    c("retire", 13'h0001, {12'h000, retire_q});
    sv;
    c("pc", 13'h1D55, pc_q);
    c("acc", 13'h0018, {5'h00, acc_q});
    c("retire", 13'h0000, {12'h000, retire_q});
    $display("jump done");
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_lit_store;
    t_or;
    t_inc_move;
    t_jump;
    conclude;
  end
endmodule // test_byte_op_execute_subset
